// ---- hbs_sequencer.v ----
// Purpose: four-channel half-bridge gate switching sequencer
// Assumes: register writes arrive already decoded from the serial frame
// Notes: gate outputs are phase and current codes for the analog drivers
`timescale 1ns/10ps
`include "hbs_regs.vh"

// Summary of operation
// - high gate switches in pre-charge then slew; low gate is a plain stage
// - low gate current units are four times (channel slew current code + 1)
// - pre-charge current for pre-charge time, then slew current until timeout
// - after timeout the high gate falls back to a limited hold current
// - set a, bit 10 clear: blanking, fall and rise pre-charge, pre-charge time
// - set b, bit 10 set: overload threshold, detection delay, slew current
// - shared register holds one de-glitch type bit per channel in bits 3..0
// - separate rise and fall pre-charge currents, one pre-charge time
// - one slew current selection serves both slopes
// - detection delay code times the overload check after switching
// - blanking code sets the cross-conduction gap
// - pwm input is filtered with one time for both edges
// - with type bit 0 the filter time covers the whole sequence so each started one completes
// - type bit 0: filter time is blanking plus pre-charge plus delay
// - type bit 1: filter time is pre-charge plus delay
// - register driven switching runs both phases but skips the filter
// - disabled channel has both gates off; polarity and pwm bits pick mode
// - pwm high turns on the polarity side and off its complement
// - source select bit 0 routes pwm input one, 1 routes input two
module hbs_sequencer #(
  parameter NCH = 4,
  parameter CW = 12,
  parameter TIMEOUT_CYC = `HBS_CYC(`HBS_TIMEOUT_NS)
) (
  input wire i_mclk,
  input wire i_srst,
  input wire i_wr_en,
  input wire [2:0] i_wr_addr,
  input wire [10:0] i_wr_data,
  input wire [3:0] i_rd_addr,
  output wire [10:0] o_rd_data,
  input wire [NCH-1:0] i_channel_enable,
  input wire [NCH-1:0] i_channel_polarity,
  input wire [NCH-1:0] i_channel_pwm_select,
  input wire [NCH-1:0] i_pwm_source_sel,
  input wire [1:0] i_pwm_input,
  output wire [NCH-1:0] o_high_gate_out,
  output wire [2*NCH-1:0] o_high_phase,
  output wire [3*NCH-1:0] o_high_current_sel,
  output wire [NCH-1:0] o_timeout_hold_current,
  output wire [NCH-1:0] o_low_gate_out,
  output wire [6*NCH-1:0] o_low_current_units,
  output wire [NCH-1:0] o_blanking,
  output wire [NCH-1:0] o_overload_check,
  output wire [3*NCH-1:0] o_overload_threshold_sel
);

  // ======================================
  // sequencer states
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_BLANK = 3'h1;
  localparam [2:0] S_PRC = 3'h2;
  localparam [2:0] S_SLEW = 3'h3;
  localparam [2:0] S_HOLD = 3'h4;
  localparam [CW-1:0] TO_C = TIMEOUT_CYC[CW-1:0];
  // interval counts in whole cycles, cut to the counter width on purpose
  localparam integer BLK0_I = `HBS_CYC(`HBS_BLANK0_NS);
  localparam integer BLK1_I = `HBS_CYC(`HBS_BLANK1_NS);
  localparam integer BLK2_I = `HBS_CYC(`HBS_BLANK2_NS);
  localparam integer BLK3_I = `HBS_CYC(`HBS_BLANK3_NS);
  localparam integer PRC0_I = `HBS_CYC(`HBS_PRC0_NS);
  localparam integer PRC1_I = `HBS_CYC(`HBS_PRC1_NS);
  localparam integer PRC2_I = `HBS_CYC(`HBS_PRC2_NS);
  localparam integer PRC3_I = `HBS_CYC(`HBS_PRC3_NS);
  localparam integer STEP_I = `HBS_CYC(`HBS_DLY_STEP_NS);

  // ======================================
  // interval lookups
  function [CW-1:0] blank_cyc;
    input [1:0] code;
    begin
      case (code)
        2'h0: blank_cyc = BLK0_I[CW-1:0];
        2'h1: blank_cyc = BLK1_I[CW-1:0];
        2'h2: blank_cyc = BLK2_I[CW-1:0];
        default: blank_cyc = BLK3_I[CW-1:0];
      endcase
    end
  endfunction

  function [CW-1:0] prc_cyc;
    input [1:0] code;
    begin
      case (code)
        2'h0: prc_cyc = PRC0_I[CW-1:0];
        2'h1: prc_cyc = PRC1_I[CW-1:0];
        2'h2: prc_cyc = PRC2_I[CW-1:0];
        default: prc_cyc = PRC3_I[CW-1:0];
      endcase
    end
  endfunction

  // delay steps are (code + 1) times the step time
  function [CW-1:0] dly_cyc;
    input [3:0] code;
    reg [CW-1:0] step;
    begin
      step = STEP_I[CW-1:0];
      dly_cyc = step * ({{(CW-4){1'b0}}, code} + 1'b1);
    end
  endfunction

  // ======================================
  // configuration storage
  reg [9:0] cfg_a_reg [0:NCH-1];
  reg [9:0] cfg_b_reg [0:NCH-1];
  reg [NCH-1:0] dgl_reg;
  reg [10:0] rd_data_reg;
  integer k;

  // writes: bit 10 of a channel word picks set a or set b
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      for (k = 0; k < NCH; k = k + 1)
      begin
        cfg_a_reg[k] <= `HBS_CFG_RST;
        cfg_b_reg[k] <= `HBS_CFG_RST;
      end
      dgl_reg <= `HBS_DGL_RST;
    end
    else if (i_wr_en)
    begin
      if (i_wr_addr == `HBS_WADDR_DGL)
        dgl_reg <= i_wr_data[NCH-1:0];
      else if (i_wr_addr < NCH)
      begin
        if (i_wr_data[`HBS_SEL_B_BIT])
          cfg_b_reg[i_wr_addr[1:0]] <= i_wr_data[9:0];
        else
          cfg_a_reg[i_wr_addr[1:0]] <= i_wr_data[9:0];
      end
    end
  end

  // read back: set b shows bit 10 set, unused bits read zero
  always @(posedge i_mclk)
  begin
    if (i_srst)
      rd_data_reg <= 11'h000;
    else
    begin
      case (i_rd_addr[3:2])
        `HBS_RGRP_A: rd_data_reg <= {1'b0, cfg_a_reg[i_rd_addr[1:0]]};
        `HBS_RGRP_B: rd_data_reg <= {1'b1, cfg_b_reg[i_rd_addr[1:0]]};
        `HBS_RGRP_DGL: rd_data_reg <= (i_rd_addr[1:0] == 2'h0) ?
                                      {7'h00, dgl_reg} : 11'h000;
        default: rd_data_reg <= 11'h000;
      endcase
    end
  end

  assign o_rd_data = rd_data_reg;

  // ======================================
  // per-channel sequencers
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : chan
      // field extraction
      wire [1:0] blk_sel = cfg_a_reg[g][`HBS_A_BLANK_LSB +: 2];
      wire [2:0] pcf_sel = cfg_a_reg[g][`HBS_A_PCF_LSB +: 3];
      wire [2:0] pcr_sel = cfg_a_reg[g][`HBS_A_PCR_LSB +: 3];
      wire [1:0] tpc_sel = cfg_a_reg[g][`HBS_A_TPC_LSB +: 2];
      wire [2:0] vds_sel = cfg_b_reg[g][`HBS_B_VDS_LSB +: 3];
      wire [3:0] dly_sel = cfg_b_reg[g][`HBS_B_DLY_LSB +: 4];
      wire [2:0] sr_sel = cfg_b_reg[g][`HBS_B_SR_LSB +: 3];
      wire [CW-1:0] blk_c = blank_cyc(blk_sel);
      wire [CW-1:0] prc_c = prc_cyc(tpc_sel);
      wire [CW-1:0] dly_c = dly_cyc(dly_sel);
      wire [CW-1:0] dgl_c;
      wire raw;
      wire filt;
      wire lvl;
      wire tgt_hi;
      wire tgt_lo;
      wire hi_up;
      reg [2:0] st_reg;
      reg [1:0] app_reg;
      reg rise_reg;
      reg lo_on_reg;
      reg [CW-1:0] cnt_reg;
      reg [CW-1:0] ovl_cnt_reg;
      reg ovl_arm_reg;
      reg ovl_pulse_reg;

      // filter time from the type bit
      assign dgl_c = dgl_reg[g] ? (prc_c + dly_c)
                                : (blk_c + prc_c + dly_c);
      // input routing
      assign raw = i_pwm_input[i_pwm_source_sel[g]];

      hbs_deglitch #(
        .CW(CW)
      ) u_dgl (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_raw(raw),
        .i_track(~i_channel_pwm_select[g]),
        .i_dgl_cycles(dgl_c),
        .o_filt(filt)
      );

      // requested gate pair
      assign lvl = i_channel_pwm_select[g] ? filt : 1'b1;
      assign tgt_hi = i_channel_enable[g] &
                      (i_channel_polarity[g] ? lvl : ~lvl);
      assign tgt_lo = i_channel_enable[g] &
                      (i_channel_polarity[g] ? ~lvl : lvl);
      assign hi_up = rise_reg & (st_reg != S_IDLE) & (st_reg != S_BLANK);

      // sequence: falling pre-charge, blanking, then the new side comes on
      always @(posedge i_mclk)
      begin
        if (i_srst)
        begin
          st_reg <= S_IDLE;
          app_reg <= 2'h0;
          rise_reg <= 1'b0;
          lo_on_reg <= 1'b0;
          cnt_reg <= {CW{1'b0}};
          ovl_cnt_reg <= {CW{1'b0}};
          ovl_arm_reg <= 1'b0;
          ovl_pulse_reg <= 1'b0;
        end
        else
        begin
          ovl_pulse_reg <= 1'b0;
          // overload check timer from the moment a gate turns on
          if (ovl_arm_reg)
          begin
            ovl_cnt_reg <= ovl_cnt_reg + 1'b1;
            if (ovl_cnt_reg >= dly_c - 1'b1)
            begin
              ovl_pulse_reg <= 1'b1;
              ovl_arm_reg <= 1'b0;
            end
          end
          if ({tgt_hi, tgt_lo} != app_reg)
          begin
            app_reg <= {tgt_hi, tgt_lo};
            lo_on_reg <= 1'b0;
            cnt_reg <= {CW{1'b0}};
            ovl_arm_reg <= 1'b0;
            if (hi_up)
            begin
              rise_reg <= 1'b0; // falling pre-charge first
              st_reg <= S_PRC;
            end
            else if (tgt_hi | tgt_lo)
            begin
              rise_reg <= 1'b0;
              st_reg <= S_BLANK;
            end
            else
            begin
              rise_reg <= 1'b0;
              st_reg <= S_IDLE;
            end
          end
          else
          begin
            case (st_reg)
              S_BLANK:
              begin
                cnt_reg <= cnt_reg + 1'b1;
                if (cnt_reg >= blk_c - 1'b1)
                begin
                  cnt_reg <= {CW{1'b0}};
                  ovl_cnt_reg <= {CW{1'b0}};
                  ovl_arm_reg <= 1'b1;
                  if (app_reg[1])
                  begin
                    rise_reg <= 1'b1;
                    st_reg <= S_PRC;
                  end
                  else
                  begin
                    lo_on_reg <= 1'b1;
                    st_reg <= S_IDLE;
                  end
                end
              end
              S_PRC:
              begin
                cnt_reg <= cnt_reg + 1'b1;
                if (cnt_reg >= prc_c - 1'b1)
                begin
                  cnt_reg <= {CW{1'b0}};
                  if (rise_reg | ~app_reg[0])
                    st_reg <= S_SLEW;
                  else
                    st_reg <= S_BLANK;
                end
              end
              S_SLEW:
              begin
                cnt_reg <= cnt_reg + 1'b1;
                if (cnt_reg >= TO_C - 1'b1)
                begin
                  cnt_reg <= {CW{1'b0}};
                  st_reg <= rise_reg ? S_HOLD : S_IDLE;
                end
              end
              S_HOLD:
                st_reg <= S_HOLD;
              S_IDLE:
                st_reg <= S_IDLE;
              default:
                st_reg <= S_IDLE;
            endcase
          end
        end
      end

      // ======================================
      // gate outputs
      assign o_high_gate_out[g] = hi_up;
      assign o_high_phase[2*g +: 2] = (st_reg == S_PRC) ? 2'h1 :
                                      (st_reg == S_SLEW) ? 2'h2 :
                                      (st_reg == S_HOLD) ? 2'h3 : 2'h0;
      // pre-charge current by slope, slew current for both slopes
      assign o_high_current_sel[3*g +: 3] =
        (st_reg == S_PRC) ? (rise_reg ? pcr_sel : pcf_sel) :
        (st_reg == S_SLEW) ? sr_sel : 3'h0;
      assign o_timeout_hold_current[g] = (st_reg == S_HOLD);
      assign o_low_gate_out[g] = lo_on_reg;
      // slew code s means s+1 units; the low stage takes four times that
      assign o_low_current_units[6*g +: 6] =
        lo_on_reg ? {({1'b0, sr_sel} + 4'h1), 2'h0} : 6'h00;
      assign o_blanking[g] = (st_reg == S_BLANK);
      assign o_overload_check[g] = ovl_pulse_reg;
      assign o_overload_threshold_sel[3*g +: 3] = vds_sel;
    end
  endgenerate

endmodule // hbs_sequencer

// ---- hbs_regs.vh ----
// Purpose: constants of the half-bridge switching sequencer
// Assumes: 40 MHz sequencer clock
// Notes: times are in ns, cycle counts derived from them
`ifndef HBS_REGS_VH
`define HBS_REGS_VH

// ======================================
// clock and time conversion
`define HBS_CLK_NS 25
// least time: round up to whole cycles
`define HBS_CYC(ns) (((ns) + `HBS_CLK_NS - 1) / `HBS_CLK_NS)

// ======================================
// write addresses (data bit 10 picks set a or b)
`define HBS_WADDR_DGL 3'h4
// read addresses: [3:2] selects the group, [1:0] the channel
`define HBS_RGRP_A 2'h0
`define HBS_RGRP_B 2'h1
`define HBS_RGRP_DGL 2'h2
`define HBS_SEL_B_BIT 10

// ======================================
// field positions of timing set a
`define HBS_A_BLANK_LSB 8
`define HBS_A_PCF_LSB 5
`define HBS_A_PCR_LSB 2
`define HBS_A_TPC_LSB 0
// field positions of timing set b
`define HBS_B_VDS_LSB 7
`define HBS_B_DLY_LSB 3
`define HBS_B_SR_LSB 0

// ======================================
// reset values
`define HBS_CFG_RST 10'h000
`define HBS_DGL_RST 4'h0

// ======================================
// interval tables in ns
`define HBS_BLANK0_NS 250
`define HBS_BLANK1_NS 500
`define HBS_BLANK2_NS 1000
`define HBS_BLANK3_NS 2000
`define HBS_PRC0_NS 250
`define HBS_PRC1_NS 500
`define HBS_PRC2_NS 750
`define HBS_PRC3_NS 1000
`define HBS_DLY_STEP_NS 500
`define HBS_TIMEOUT_NS 50000

`endif

// ---- hbs_deglitch.v ----
// Purpose: symmetrical de-glitch of one routed pwm input
// Assumes: input synchronous to i_mclk
// Notes: same filter time for both edges
`timescale 1ns/10ps
module hbs_deglitch #(
  parameter CW = 12
) (
  input wire i_mclk,
  input wire i_srst,
  input wire i_raw,
  input wire i_track,
  input wire [CW-1:0] i_dgl_cycles,
  output wire o_filt
);

  reg filt_reg;
  reg [CW-1:0] cnt_reg;

  // ======================================
  // filter
  // the output only moves after the input held its new level for the
  // whole filter time, so with type bit 0 a started sequence is never cut short
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      filt_reg <= 1'b0;
      cnt_reg <= {CW{1'b0}};
    end
    else if (i_track)
    begin
      filt_reg <= i_raw; // no filtering outside pwm mode
      cnt_reg <= {CW{1'b0}};
    end
    else if (i_raw == filt_reg)
    begin
      cnt_reg <= {CW{1'b0}};
    end
    else if (cnt_reg >= i_dgl_cycles - 1'b1)
    begin
      filt_reg <= i_raw;
      cnt_reg <= {CW{1'b0}};
    end
    else
    begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign o_filt = filt_reg;

endmodule // hbs_deglitch

// ---- hbs_sequencer_properties.sv ----
// Purpose: port checks of the half-bridge gate sequencer
// Assumes: timed checks watch channel 0 only
// Notes: shadow copies of channel 0 settings come from the write port
`timescale 1ns/10ps
// ==========================================
// checker
module hbs_seq_props #(
  parameter NCH = 4,
  parameter TIMEOUT_CYC = 2000
) (
  input wire i_mclk,
  input wire i_srst,
  input wire i_wr_en,
  input wire [2:0] i_wr_addr,
  input wire [10:0] i_wr_data,
  input wire [10:0] o_rd_data,
  input wire [NCH-1:0] i_channel_enable,
  input wire [NCH-1:0] o_high_gate_out,
  input wire [2*NCH-1:0] o_high_phase,
  input wire [3*NCH-1:0] o_high_current_sel,
  input wire [NCH-1:0] o_timeout_hold_current,
  input wire [NCH-1:0] o_low_gate_out,
  input wire [6*NCH-1:0] o_low_current_units,
  input wire [NCH-1:0] o_blanking,
  input wire [NCH-1:0] o_overload_check,
  input wire [3*NCH-1:0] o_overload_threshold_sel
);
  reg [9:0] a_reg;
  reg [9:0] b_reg;
  reg [3:0] key_reg;
  reg [15:0] run_reg;
  wire [1:0] ph = o_high_phase[1:0];
  wire up = o_high_gate_out[0];
  wire [3:0] key = {up, ph, o_blanking[0]};
  wire [15:0] prc_cyc = 16'd10 * ({14'h0, a_reg[1:0]} + 16'd1);
  wire [15:0] blank_cyc = 16'd10 << a_reg[9:8];
  // shadow settings and length of the current gate state
  always @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      a_reg <= 10'h000;
      b_reg <= 10'h000;
      key_reg <= 4'h0;
      run_reg <= 16'h0000;
    end
    else
    begin
      key_reg <= key;
      run_reg <= (key == key_reg) ? run_reg + 16'h0001 : 16'h0001;
      if (i_wr_en && i_wr_addr == 3'h0 && i_wr_data[10])
        b_reg <= i_wr_data[9:0];
      if (i_wr_en && i_wr_addr == 3'h0 && !i_wr_data[10])
        a_reg <= i_wr_data[9:0];
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);
  // ==========================================
  // sequence steps of the rising high gate
  sequence blank_to_pc;
    key_reg == 4'b0001 && key == 4'b1010;
  endsequence
  sequence pc_to_slew;
    key_reg == 4'b1010 && key == 4'b1100;
  endsequence
  sequence slew_to_hold;
    key_reg == 4'b1100 && key == 4'b1110;
  endsequence
  gates_exclusive_a: assert property ((o_high_gate_out & o_low_gate_out) == '0)
    else $error("high and low gate on together");
  disabled_off_a: assert property (!i_channel_enable[0] [*3] |-> !up && !o_low_gate_out[0])
    else $error("disabled channel still drives a gate");
  low_units_a: assert property (o_low_gate_out[0] |->
    o_low_current_units[5:0] == ({3'h0, b_reg[2:0]} + 6'd1) << 2)
    else $error("low gate current not four times slew");
  blank_time_a: assert property (blank_to_pc |-> run_reg == blank_cyc)
    else $error("blanking length wrong");
  pc_time_a: assert property (pc_to_slew |-> run_reg == prc_cyc)
    else $error("pre-charge length wrong");
  slew_time_a: assert property (slew_to_hold |-> run_reg == TIMEOUT_CYC)
    else $error("slew length differs from timeout");
  hold_flag_a: assert property (o_timeout_hold_current[0] == (up && ph == 2'd3))
    else $error("hold current flag wrong");
  pc_code_a: assert property (ph == 2'd1 |->
    o_high_current_sel[2:0] == (up ? a_reg[4:2] : a_reg[7:5]))
    else $error("pre-charge current code wrong");
  slew_code_a: assert property (ph == 2'd2 |-> o_high_current_sel[2:0] == b_reg[2:0])
    else $error("slew current code wrong");
  threshold_a: assert property (o_overload_threshold_sel[2:0] == b_reg[9:7])
    else $error("overload threshold code wrong");
  check_pulse_a: assert property (o_overload_check[0] |=> !o_overload_check[0])
    else $error("overload check longer than one cycle");
  reset_clear_a: assert property ($fell(i_srst) |->
    o_high_phase == '0 && o_low_gate_out == '0 && o_rd_data == 11'h000)
    else $error("outputs not clear after reset");
endmodule // hbs_seq_props

bind hbs_sequencer hbs_seq_props #(.NCH(NCH), .TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
  .i_mclk(i_mclk), .i_srst(i_srst), .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr),
  .i_wr_data(i_wr_data), .o_rd_data(o_rd_data), .i_channel_enable(i_channel_enable),
  .o_high_gate_out(o_high_gate_out), .o_high_phase(o_high_phase),
  .o_high_current_sel(o_high_current_sel), .o_timeout_hold_current(o_timeout_hold_current),
  .o_low_gate_out(o_low_gate_out), .o_low_current_units(o_low_current_units),
  .o_blanking(o_blanking), .o_overload_check(o_overload_check),
  .o_overload_threshold_sel(o_overload_threshold_sel));

// ---- hbs_switch_model.sv ----
// Purpose: external switch pair of each half-bridge channel
// Assumes: gate codes settle within one clock
// Notes: a node with both switches off floats and toggles
`timescale 1ns/10ps
// ==========================================
// switch model
module hbs_switch_model (
  input wire i_mclk,
  input wire [3:0] i_high_gate_out,
  input wire [3:0] i_low_gate_out,
  output reg [3:0] o_node = 4'h0,
  output wire [3:0] o_shoot
);
  // both switches on shorts the supply
  assign o_shoot = i_high_gate_out & i_low_gate_out;
  // high switch pulls up, low pulls down, neither leaves it floating
  always @(posedge i_mclk)
    o_node <= i_high_gate_out | (~i_low_gate_out & ~o_node);
endmodule // hbs_switch_model

// ---- testbench.sv ----
// Purpose: self-checking bench of the half-bridge gate sequencer
// Assumes: timeout shortened to 50 cycles
// Notes: timed scenarios run on channel 0
`timescale 1ns/10ps
module testbench;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg wr_en = 1'b0;
  reg [2:0] wr_addr = 3'h0;
  reg [10:0] wr_data = 11'h000;
  reg [3:0] rd_addr = 4'h0;
  reg [3:0] en = 4'h0;
  reg [3:0] pol = 4'h0;
  reg [3:0] pws = 4'h0;
  reg [3:0] pss = 4'h0;
  reg [1:0] pwm = 2'h0;
  wire [10:0] rd_data;
  wire [3:0] hg, hold, lg, blk, ovc, node, shoot;
  wire [7:0] hph;
  wire [11:0] hcs, ovt;
  wire [23:0] lcu;
  wire [3:0] key = {hg[0], hph[1:0], lg[0]};
  integer num_errors = 0;
  integer checks_done = 0;
  integer seed = 32'h0b7b1710;
  integer n, ch, t, s, dg;
  reg [9:0] a0, b0, ra, rb;
  hbs_sequencer #(.TIMEOUT_CYC(50)) uut (.i_mclk(clk), .i_srst(srst), .i_wr_en(wr_en),
    .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
    .i_channel_enable(en), .i_channel_polarity(pol), .i_channel_pwm_select(pws),
    .i_pwm_source_sel(pss), .i_pwm_input(pwm), .o_high_gate_out(hg), .o_high_phase(hph),
    .o_high_current_sel(hcs), .o_timeout_hold_current(hold), .o_low_gate_out(lg),
    .o_low_current_units(lcu), .o_blanking(blk), .o_overload_check(ovc),
    .o_overload_threshold_sel(ovt));
  hbs_switch_model u_sw (.i_mclk(clk), .i_high_gate_out(hg), .i_low_gate_out(lg),
    .o_node(node), .o_shoot(shoot));
  // ==========================================
  // clock and helpers
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // filter length in cycles for a type and the channel settings
  function integer dgl_cyc(input integer ty, input [9:0] a, input [9:0] b);
    begin
      dgl_cyc = 10 * (a[1:0] + 1) + 20 * (b[6:3] + 1);
      if (ty == 0)
        dgl_cyc = dgl_cyc + (10 << a[9:8]);
    end
  endfunction
  task test_done;
    begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        num_errors = num_errors + 1;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [2:0] ad, input [10:0] d);
    begin
      @(negedge clk);
      wr_en = 1'b1;
      wr_addr = ad;
      wr_data = d;
      @(negedge clk);
      wr_en = 1'b0;
    end
  endtask
  task rd(input [3:0] ad, input [10:0] e);
    begin
      @(negedge clk);
      rd_addr = ad;
      @(negedge clk);
      chk("rd_data", e, rd_data);
    end
  endtask
  // bounded wait for a gate state, n returns the cycles spent
  task wait_key(input [3:0] k);
    begin
      n = 0;
      while (key !== k && n < 1000)
      begin
        @(negedge clk);
        n = n + 1;
      end
      if (n == 1000)
      begin
        num_errors = num_errors + 1;
        $display("Error gate_state expected %h seen %h", k, key);
        test_done;
      end
    end
  endtask
  // bounded wait for the overload check pulse of channel 0
  task wait_ovl;
    begin
      n = 0;
      while (ovc[0] !== 1'b1 && n < 1000)
      begin
        @(negedge clk);
        n = n + 1;
      end
      if (n == 1000)
      begin
        num_errors = num_errors + 1;
        $display("Error overload_check expected 1 seen %b", ovc[0]);
        test_done;
      end
    end
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    rd(4'h0, 11'h000);
    for (ch = 0; ch < 4; ch = ch + 1)
    begin
      ra = $random(seed);
      rb = $random(seed);
      wr(ch[2:0], {1'b0, ra});
      wr(ch[2:0], {1'b1, rb});
      rd({2'h0, ch[1:0]}, {1'b0, ra});
      rd({2'h1, ch[1:0]}, {1'b1, rb});
      chk("threshold", rb[9:7], ovt[3*ch+:3]);
      if (ch == 0)
      begin
        a0 = ra;
        b0 = rb;
      end
    end
    wr(3'h5, 11'h7ff);
    rd(4'h0, {1'b0, a0});
    rd(4'hc, 11'h000);
    wr(3'h4, 11'h7f5);
    rd(4'h8, 11'h005);
    $display("test registers done");
    en = 4'h1;
    wait_key(4'b0001);
    wait_ovl;
    chk("ovl_delay", 20 * (b0[6:3] + 1), n);
    @(negedge clk);
    chk("low_units", ({3'h0, b0[2:0]} + 6'd1) << 2, lcu[5:0]);
    chk("node_low", 1'b0, node[0]);
    pol = 4'h1;
    wait_key(4'b0000);
    chk("unfiltered", 1'b1, n < 4);
    wait_key(4'b1010);
    wait_key(4'b1100);
    chk("slew_code", b0[2:0], hcs[2:0]);
    wait_key(4'b1110);
    chk("hold", 1'b1, hold[0]);
    chk("node_high", 1'b1, node[0]);
    en = 4'h0;
    wait_key(4'b0000);
    $display("test register switching done");
    for (t = 0; t < 2; t = t + 1)
      for (s = 0; s < 2; s = s + 1)
      begin
        dg = dgl_cyc(t, a0, b0);
        wr(3'h4, {10'h000, t[0]});
        pwm = {~s[0], s[0]};
        pss = {3'h0, s[0]};
        pws = 4'h1;
        en = 4'h1;
        wait_key(4'b0001);
        pwm[s] = 1'b1;
        repeat (dg - 2) @(negedge clk);
        pwm[s] = 1'b0;
        repeat (dg + 20) @(negedge clk);
        chk("glitch", 1'b1, lg[0]);
        pwm[s] = 1'b1;
        wait_key(4'b0000);
        chk("rise_delay", 1'b1, n >= dg - 1 && n <= dg + 3);
        wait_key(4'b1110);
        pwm[s] = 1'b0;
        wait_key(4'b0010);
        chk("fall_delay", 1'b1, n >= dg - 1 && n <= dg + 3);
        wait_key(4'b0001);
        repeat (2) @(negedge clk);
        chk("node_pwm", 1'b0, node[0]);
        en = 4'h0;
        wait_key(4'b0000);
        $display("test filter type %0d source %0d done", t, s);
      end
    pws = 4'h0;
    en = 4'h1;
    wait_key(4'b1100);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk("reset_gates", 4'h0, hg | lg | shoot);
    rd(4'h1, 11'h000);
    $display("test second reset done");
    test_done;
  end
endmodule // testbench
